// >>> dsip_pkg.sv
// Constants and types shared by the serial input port design
package dsip_pkg;

    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam int          FRAME_BITS  = 16;
    localparam int          CNT_W       = 5;
    localparam logic [4:0]  CNT_FULL    = 5'h10;
    localparam int          CTRL_HI_POS = 15;
    localparam int          CTRL_LO_POS = 14;
    localparam int          CODE_MSB    = 13;
    localparam int          CODE_MAX_W  = 14;

    // ------------------------------------------------------------------
    // Control codes
    // ------------------------------------------------------------------
    localparam logic [1:0]  CTRL_LOAD   = 2'h0;
    localparam logic [1:0]  CTRL_RISE   = 2'h3;

    // ------------------------------------------------------------------
    // Reset values and sizes
    // ------------------------------------------------------------------
    localparam logic [15:0] WORD_RST    = 16'h0000;
    localparam logic [13:0] CODE_RST    = 14'h0000;
    localparam logic [4:0]  CNT_RST     = 5'h00;
    localparam int          FIFO_DEPTH  = 16;
    localparam int          SYNC_STAGES = 3;

    // ------------------------------------------------------------------
    // Frame tracking states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FRAME,
        ST_CHECK,
        ST_PUSH
    } dsip_state_t;

endpackage

// >>> dsip_stream_if.sv
// Valid/ready word stream between the port logic and its buffer
`timescale 1ns/1ps
interface dsip_stream_if #(
    parameter int WIDTH = 14
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface

// >>> dsip_sync3.sv
// Three-stage level synchroniser with agreement filter
`timescale 1ns/1ps
module dsip_sync3 #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic async_in,
    output logic      level_r
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // ------------------------------------------------------------------
    // Stages; first stage feeds only the second
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s1_r    <= RST_VAL;
            s2_r    <= RST_VAL;
            s3_r    <= RST_VAL;
            level_r <= RST_VAL;
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_r <= s3_r;
            end
        end
    end
endmodule

// >>> dsip_fifo.sv
// Word buffer with registered read data; full counts the output stage, empty does not
`timescale 1ns/1ps
module dsip_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    input  wire logic  clk_sys,
    input  wire logic  reset,
    dsip_stream_if.dst wr,
    dsip_stream_if.src rd,
    output logic       full,
    output logic       empty
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic [WIDTH-1:0] out_data_r;
    logic             out_valid_r;
    logic             do_wr;
    logic             do_rd;

    // ------------------------------------------------------------------
    // Handshake terms
    // ------------------------------------------------------------------
    // Output stage counts as a slot, so exactly DEPTH words are held
    assign full     = ((count_r + (AW+1)'(out_valid_r)) == (AW+1)'(DEPTH));
    assign empty    = (count_r == '0);
    assign wr.ready = !full;
    assign do_wr    = wr.valid && !full;
    // Refill output stage when it is free or being drained
    assign do_rd    = !empty && (!out_valid_r || rd.ready);
    assign rd.valid = out_valid_r;
    assign rd.data  = out_data_r;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (do_wr) begin
            mem[wr_ptr_r] <= wr.data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count_r <= count_r + 1'b1;
            end else if (!do_wr && do_rd) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registered read data
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            out_valid_r <= 1'b0;
            out_data_r  <= '0;
        end else if (do_rd) begin
            out_valid_r <= 1'b1;
            out_data_r  <= mem[rd_ptr_r];
        end else if (rd.ready) begin
            out_valid_r <= 1'b0;
        end
    end
endmodule

// >>> dsip_port.sv
// Serial input port of a single-channel current-output converter
`timescale 1ns/1ps
module dsip_port
    import dsip_pkg::*;
#(
    parameter int CODE_BITS = 14,
    parameter int BUF_DEPTH = FIFO_DEPTH
) (
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    input  wire logic                  link_sclk,
    input  wire logic                  frame_sync_n,
    input  wire logic                  serial_data_in,
    output logic                       serial_data_out,
    input  wire logic                  conv_ready,
    output logic [CODE_MAX_W-1:0]      current_output_r,
    output logic                       conv_update_r,
    output logic                       edge_rise_r,
    output logic                       core_hold_r,
    output logic                       link_awake_r,
    output logic                       buf_space_r,
    output logic                       frame_err_r,
    output logic                       ctrl_reserved_r,
    output logic                       word_drop_r
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam int LOW_DROP = CODE_MAX_W - CODE_BITS;

    logic                  link_clr_r;
    logic                  cnt_clr_r;
    logic                  link_idle;
    logic [FRAME_BITS-1:0] shift_fall_r;
    logic [FRAME_BITS-1:0] shift_rise_r;
    logic [CNT_W-1:0]      cnt_fall_r;
    logic [CNT_W-1:0]      cnt_rise_r;
    logic                  sdo_r;

    logic                  fs_n_lvl;
    logic                  fs_n_prev_r;
    logic                  fs_fall;
    logic                  fs_rise;
    dsip_state_t           state_r;
    dsip_state_t           state_nxt;

    logic [FRAME_BITS-1:0] word_cap_r;
    logic [CNT_W-1:0]      cnt_cap_r;
    logic [1:0]            ctrl_cap;
    logic [CODE_MAX_W-1:0] code_cap;
    logic [CODE_MAX_W-1:0] code_mask;
    logic                  push_r;
    logic [CODE_MAX_W-1:0] push_data_r;
    logic                  buf_full;

    dsip_stream_if #(.WIDTH(CODE_MAX_W)) wr_if ();
    dsip_stream_if #(.WIDTH(CODE_MAX_W)) rd_if ();

    // ------------------------------------------------------------------
    // Power-on clear toward the link side
    // ------------------------------------------------------------------
    // Registered so the link side sees a glitch-free asynchronous clear
    always_ff @(posedge clk_sys) begin
        link_clr_r <= reset;
    end

    // Counters clear after the word is judged, not at frame close,
    // so the count still stands when the system side samples it
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt_clr_r <= 1'b0;
        end else begin
            cnt_clr_r <= (state_r == ST_CHECK);
        end
    end

    assign link_idle = cnt_clr_r | link_clr_r;

    // ------------------------------------------------------------------
    // Link domain: falling-edge shift register
    // ------------------------------------------------------------------
    // Shift contents survive frame close so they can be read back later
    always_ff @(negedge link_sclk or posedge link_clr_r) begin
        if (link_clr_r) begin
            shift_fall_r <= WORD_RST;
        end else if (!frame_sync_n) begin
            shift_fall_r <= {shift_fall_r[FRAME_BITS-2:0], serial_data_in};
        end
    end

    always_ff @(negedge link_sclk or posedge link_idle) begin
        if (link_idle) begin
            cnt_fall_r <= CNT_RST;
        end else if (!frame_sync_n && cnt_fall_r != CNT_FULL + 5'h01) begin
            cnt_fall_r <= cnt_fall_r + 5'h01;
        end
    end

    // ------------------------------------------------------------------
    // Link domain: rising-edge shift register
    // ------------------------------------------------------------------
    // Both edges always collect; the system side picks by edge mode,
    // so the mode never has to cross into a clock that may be stopped
    always_ff @(posedge link_sclk or posedge link_clr_r) begin
        if (link_clr_r) begin
            shift_rise_r <= WORD_RST;
        end else if (!frame_sync_n) begin
            shift_rise_r <= {shift_rise_r[FRAME_BITS-2:0], serial_data_in};
        end
    end

    always_ff @(posedge link_sclk or posedge link_idle) begin
        if (link_idle) begin
            cnt_rise_r <= CNT_RST;
        end else if (!frame_sync_n && cnt_rise_r != CNT_FULL + 5'h01) begin
            cnt_rise_r <= cnt_rise_r + 5'h01;
        end
    end

    // ------------------------------------------------------------------
    // Link domain: readback output
    // ------------------------------------------------------------------
    // Limitation: readback follows the falling-edge register only
    always_ff @(posedge link_sclk or posedge link_clr_r) begin
        if (link_clr_r) begin
            sdo_r <= 1'b0;
        end else if (!frame_sync_n) begin
            sdo_r <= shift_fall_r[FRAME_BITS-1];
        end
    end

    assign serial_data_out = sdo_r;

    // ------------------------------------------------------------------
    // Frame sync into the system clock
    // ------------------------------------------------------------------
    dsip_sync3 #(
        .RST_VAL (1'b1)
    ) u_fs_sync (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .async_in (frame_sync_n),
        .level_r  (fs_n_lvl)
    );

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fs_n_prev_r <= 1'b1;
        end else begin
            fs_n_prev_r <= fs_n_lvl;
        end
    end

    assign fs_fall = fs_n_prev_r && !fs_n_lvl;
    assign fs_rise = !fs_n_prev_r && fs_n_lvl;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            link_awake_r <= 1'b0;
        end else if (fs_fall) begin
            link_awake_r <= 1'b1;
        end else if (fs_rise) begin
            link_awake_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Frame tracking
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (fs_fall) begin
                    state_nxt = ST_FRAME;
                end
            end
            ST_FRAME: begin
                if (fs_rise) begin
                    state_nxt = ST_CHECK;
                end
            end
            ST_CHECK: begin
                state_nxt = ST_PUSH;
            end
            ST_PUSH: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Word capture at frame close
    // ------------------------------------------------------------------
    // Link registers are static once frame sync is high, so a
    // copy after the synchronised rise is safe
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            word_cap_r <= WORD_RST;
            cnt_cap_r  <= CNT_RST;
        end else if (state_r == ST_FRAME && fs_rise) begin
            word_cap_r <= edge_rise_r ? shift_rise_r : shift_fall_r;
            cnt_cap_r  <= edge_rise_r ? cnt_rise_r : cnt_fall_r;
        end
    end

    assign ctrl_cap  = {word_cap_r[CTRL_HI_POS], word_cap_r[CTRL_LO_POS]};
    assign code_mask = {CODE_MAX_W{1'b1}} << LOW_DROP;
    assign code_cap  = word_cap_r[CODE_MSB:0] & code_mask;

    // ------------------------------------------------------------------
    // Control decode
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            edge_rise_r <= 1'b0;
        end else if (state_r == ST_CHECK && cnt_cap_r == CNT_FULL
                     && ctrl_cap == CTRL_RISE) begin
            edge_rise_r <= 1'b1;
        end
    end

    // Hold stops converter updates until the following frame opens
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            core_hold_r <= 1'b0;
        end else if (state_r == ST_CHECK && cnt_cap_r == CNT_FULL
                     && ctrl_cap == CTRL_RISE && !edge_rise_r) begin
            core_hold_r <= 1'b1;
        end else if (fs_fall) begin
            core_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            frame_err_r     <= 1'b0;
            ctrl_reserved_r <= 1'b0;
        end else begin
            frame_err_r     <= (state_r == ST_CHECK) && (cnt_cap_r != CNT_FULL);
            ctrl_reserved_r <= (state_r == ST_CHECK) && (cnt_cap_r == CNT_FULL)
                               && (ctrl_cap != CTRL_LOAD) && (ctrl_cap != CTRL_RISE);
        end
    end

    // ------------------------------------------------------------------
    // Buffer fill
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            push_r      <= 1'b0;
            push_data_r <= CODE_RST;
            word_drop_r <= 1'b0;
        end else begin
            push_r      <= 1'b0;
            word_drop_r <= 1'b0;
            if (state_r == ST_CHECK && cnt_cap_r == CNT_FULL && ctrl_cap == CTRL_LOAD) begin
                // Full buffer cannot stall the host, so the word is lost
                if (wr_if.ready) begin
                    push_r      <= 1'b1;
                    push_data_r <= code_cap;
                end else begin
                    word_drop_r <= 1'b1;
                end
            end
        end
    end

    assign wr_if.valid = push_r;
    assign wr_if.data  = push_data_r;

    dsip_fifo #(
        .WIDTH (CODE_MAX_W),
        .DEPTH (BUF_DEPTH)
    ) u_fifo (
        .clk_sys (clk_sys),
        .reset   (reset),
        .wr      (wr_if),
        .rd      (rd_if),
        .full    (buf_full),
        .empty   ()
    );

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            buf_space_r <= 1'b1;
        end else begin
            buf_space_r <= !buf_full;
        end
    end

    // ------------------------------------------------------------------
    // Converter register
    // ------------------------------------------------------------------
    assign rd_if.ready = conv_ready && !core_hold_r;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            current_output_r <= CODE_RST;
            conv_update_r    <= 1'b0;
        end else begin
            conv_update_r <= 1'b0;
            if (rd_if.valid && rd_if.ready) begin
                current_output_r <= rd_if.data;
                conv_update_r    <= 1'b1;
            end
        end
    end

endmodule

// >>> dsip_port_monitor.sv
// Concurrent checks on the serial input port outputs
`timescale 1ns/1ps
module dsip_port_monitor
    import dsip_pkg::*;
#(
    parameter int CODE_BITS = 14
) (
    input wire logic                  clk_sys,
    input wire logic                  reset,
    input wire logic                  frame_sync_n,
    input wire logic                  conv_ready,
    input wire logic [CODE_MAX_W-1:0] current_output_r,
    input wire logic                  conv_update_r,
    input wire logic                  edge_rise_r,
    input wire logic                  core_hold_r,
    input wire logic                  link_awake_r,
    input wire logic                  frame_err_r
);
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    wire logic [13:0] low_mask = 14'h3fff >> CODE_BITS;

    chk_low_bits_zero: assert property (@(posedge clk_sys) disable iff (reset)
        (current_output_r & low_mask) == 14'h0000) else $error("low code bits set");
    chk_reset_zero: assert property (@(posedge clk_sys)
        reset |=> current_output_r == 14'h0000 && !conv_update_r && !edge_rise_r)
        else $error("reset values wrong");
    chk_out_steady: assert property (@(posedge clk_sys) disable iff (reset)
        !conv_update_r |-> $stable(current_output_r)) else $error("output moved");
    chk_update_cause: assert property (@(posedge clk_sys) disable iff (reset)
        conv_update_r |-> $past(conv_ready) && !$past(core_hold_r))
        else $error("update without cause");
    chk_mode_sticky: assert property (@(posedge clk_sys) disable iff (reset)
        $past(edge_rise_r) |-> edge_rise_r) else $error("edge mode reverted");
    chk_hold_on_change: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(edge_rise_r) |-> ##[0:2] core_hold_r) else $error("no hold on change");
    chk_hold_blocks: assert property (@(posedge clk_sys) disable iff (reset)
        core_hold_r |=> !conv_update_r) else $error("update while held");
    chk_wake_on_fall: assert property (@(posedge clk_sys) disable iff (reset)
        $fell(frame_sync_n) |-> ##[2:8] link_awake_r) else $error("no wake");
    chk_sleep_on_rise: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(frame_sync_n) |-> ##[2:8] !link_awake_r) else $error("no sleep");
    chk_err_single: assert property (@(posedge clk_sys) disable iff (reset)
        frame_err_r |=> !frame_err_r) else $error("error pulse too long");
endmodule

// >>> dsip_host_model.sv
// Host controller model driving the serial link
`timescale 1ns/1ps
module dsip_host_model (
    output logic     link_sclk,
    output logic     frame_sync_n,
    output logic     serial_data_in,
    input wire logic serial_data_out
);
    initial begin
        link_sclk = 1'b0;
        frame_sync_n = 1'b1;
        serial_data_in = 1'b0;
    end

    // Clock stands still outside frames; split pauses it mid-frame
    task automatic send(input logic [15:0] w, input int nb, input bit rm, input bit sp,
                        output logic [15:0] rb);
        rb = 16'h0000;
        // Keeps link edges off the system clock's edges
        #1.3;
        frame_sync_n = 1'b0;
        #40;
        for (int i = 0; i < nb; i++) begin
            if (rm) begin
                serial_data_in = w[4'(15 - i)];
                #40 link_sclk = 1'b1;
                #40 link_sclk = 1'b0;
            end else begin
                link_sclk = 1'b1;
                serial_data_in = w[4'(15 - i)];
                #40;
                rb = {rb[14:0], serial_data_out};
                link_sclk = 1'b0;
                #40;
            end
            if (sp && i == 7) #400;
        end
        // Released line must not look like the last bit
        serial_data_in = ~serial_data_in;
        #40 frame_sync_n = 1'b1;
        #200;
    endtask

    // Clock edges with frame sync high
    task automatic stray();
        #1.3;
        repeat (4) begin
            #40 link_sclk = 1'b1;
            serial_data_in = ~serial_data_in;
            #40 link_sclk = 1'b0;
        end
    endtask
endmodule

// >>> dsip_port_tb.sv
// Self-checking bench for the serial input port
`timescale 1ns/1ps
module dsip_port_tb;
    import dsip_pkg::*;
    logic        clk_sys, reset, conv_ready;
    wire logic   link_sclk, frame_sync_n, serial_data_in, serial_data_out;
    logic [13:0] cur, cur8;
    logic        upd, rise_m, hold, awake, space, ferr, resv, drop;
    int          n_fail = 0, cmp_count = 0, cyc = 0;
    int          n_upd = 0, n_ferr = 0, n_resv = 0, n_drop = 0;
    logic [13:0] upd_q[$];
    logic [15:0] rb;

    dsip_port #(.CODE_BITS(14)) uut (.clk_sys(clk_sys), .reset(reset),
        .link_sclk(link_sclk), .frame_sync_n(frame_sync_n), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out), .conv_ready(conv_ready), .current_output_r(cur),
        .conv_update_r(upd), .edge_rise_r(rise_m), .core_hold_r(hold), .link_awake_r(awake),
        .buf_space_r(space), .frame_err_r(ferr), .ctrl_reserved_r(resv), .word_drop_r(drop));
    dsip_port #(.CODE_BITS(8)) uut8 (.clk_sys(clk_sys), .reset(reset),
        .link_sclk(link_sclk), .frame_sync_n(frame_sync_n), .serial_data_in(serial_data_in),
        .serial_data_out(), .conv_ready(conv_ready), .current_output_r(cur8),
        .conv_update_r(), .edge_rise_r(), .core_hold_r(), .link_awake_r(),
        .buf_space_r(), .frame_err_r(), .ctrl_reserved_r(), .word_drop_r());
    dsip_host_model host (.link_sclk(link_sclk), .frame_sync_n(frame_sync_n),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Pulses counted mid-cycle, after the launching edge settled
    always @(negedge clk_sys) begin
        if (upd === 1'b1) begin
            n_upd++;
            upd_q.push_back(cur);
        end
        if (ferr === 1'b1) n_ferr++;
        if (resv === 1'b1) n_resv++;
        if (drop === 1'b1) n_drop++;
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Link side clear releases one edge after reset drops
    task automatic do_reset();
        reset <= 1'b1;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask

    // Answer lands within nine cycles of frame end
    task automatic frame(input logic [15:0] w, input int nb, input bit rm, input bit sp);
        host.send(w, nb, rm, sp, rb);
        repeat (24) @(posedge clk_sys);
    endtask

    task automatic t_reset_vals();
        chk({2'b00, cur}, 16'h0000, "output after reset");
        chk({12'h000, rise_m, hold, awake, space}, 16'h0001, "flags after reset");
    endtask

    task automatic t_load();
        int u0;
        u0 = n_upd;
        fork
            frame(16'h2a5b, 16, 1'b0, 1'b0);
            begin
                repeat (60) @(posedge clk_sys);
                chk({15'h0000, awake}, 16'h0001, "awake in frame");
            end
        join
        chk({2'b00, cur}, 16'h2a5b, "load word");
        chk({2'b00, cur8}, 16'h2a40, "8-bit variant");
        chk(rb, 16'h0000, "readback after reset");
        chk({15'h0000, awake}, 16'h0000, "asleep after frame");
        host.stray();
        frame(16'h1c3e, 16, 1'b0, 1'b0);
        chk(rb, 16'h2a5b, "readback past stray clocks");
        chk({2'b00, cur}, 16'h1c3e, "msb first");
        frame(16'h3fff, 16, 1'b0, 1'b1);
        chk({2'b00, cur}, 16'h3fff, "two byte transfer");
        chk(16'(n_upd - u0), 16'h0003, "one update per word");
    endtask

    task automatic t_refuse();
        int f0, r0, u0;
        f0 = n_ferr;
        r0 = n_resv;
        u0 = n_upd;
        frame(16'h0001, 15, 1'b0, 1'b0);
        frame(16'h0002, 17, 1'b0, 1'b0);
        frame(16'h5555, 16, 1'b0, 1'b0);
        frame(16'h9555, 16, 1'b0, 1'b0);
        chk(16'(n_ferr - f0), 16'h0002, "bad lengths flagged");
        chk(16'(n_resv - r0), 16'h0002, "reserved codes flagged");
        chk(16'(n_upd - u0), 16'h0000, "no load on refusal");
        chk({2'b00, cur}, 16'h3fff, "output kept");
    endtask

    task automatic t_full();
        int u0;
        u0 = n_upd;
        upd_q.delete();
        conv_ready <= 1'b0;
        for (int k = 0; k < 16; k++) frame(16'h0100 + 16'(k), 16, 1'b0, 1'b0);
        chk({15'h0000, space}, 16'h0000, "buffer full");
        frame(16'h0200, 16, 1'b0, 1'b0);
        chk(16'(n_drop), 16'h0001, "word dropped when full");
        chk(16'(n_upd - u0), 16'h0000, "no drain while stalled");
        conv_ready <= 1'b1;
        for (int i = 0; i < 300 && upd_q.size() < 16; i++) @(posedge clk_sys);
        for (int k = 0; k < 16; k++) chk({2'b00, upd_q[k]}, 16'h0100 + 16'(k), "drain");
        chk({15'h0000, space}, 16'h0001, "buffer has space");
    endtask

    task automatic t_rise();
        int u0;
        u0 = n_upd;
        frame(16'hc000, 16, 1'b0, 1'b0);
        chk({14'h0000, rise_m, hold}, 16'h0003, "edge change and hold");
        chk(16'(n_upd - u0), 16'h0000, "no load on edge change");
        frame(16'h0abc, 16, 1'b1, 1'b0);
        chk({2'b00, cur}, 16'h0abc, "rising edge load");
        chk({15'h0000, hold}, 16'h0000, "hold ends at next frame");
        do_reset();
        chk({2'b00, cur}, 16'h0000, "zero after power cycle");
        chk({15'h0000, rise_m}, 16'h0000, "falling edge restored");
        frame(16'h0777, 16, 1'b0, 1'b0);
        chk({2'b00, cur}, 16'h0777, "falling edge load");
    endtask

    initial begin
        reset = 1'b1;
        conv_ready = 1'b1;
        do_reset();
        t_reset_vals();
        t_load();
        t_refuse();
        t_full();
        t_rise();
        final_report();
    end
endmodule

bind dsip_port dsip_port_monitor #(.CODE_BITS(CODE_BITS)) mon (
    .clk_sys(clk_sys), .reset(reset), .frame_sync_n(frame_sync_n),
    .conv_ready(conv_ready), .current_output_r(current_output_r),
    .conv_update_r(conv_update_r), .edge_rise_r(edge_rise_r),
    .core_hold_r(core_hold_r), .link_awake_r(link_awake_r), .frame_err_r(frame_err_r));
